// File: src/tpw_timer_pwm.sv
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "tpw_defines.svh"

module tpw_timer_pwm (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [5:0]       waveform_output_n,
  output logic [5:0]       pin_override_n,
  output logic             ovf_lunf_pulse,
  output logic             hunf_pulse,
  output logic [2:0]       cmp_pulse
);

  tpw_pkg::tpw_ctrl_t ctrl_q;
  tpw_pkg::tpw_cmd_t  cmd;
  logic               dir_q;
  logic               update_lock_q;
  logic [15:0]        cnt_q;
  logic [15:0]        per_q;
  logic [15:0]        perbuf_q;
  logic [15:0]        cmp_q [3];
  logic [15:0]        cmpbuf_q [3];
  logic [3:0]         vld_q;
  logic [7:0]         flags_q;
  logic [5:0]         wo_q;
  logic [5:0]         wo_d;
  logic [31:0]        prdata_q;
  logic [15:0]        cnt_d;
  logic               dir_d;
  logic               at_top;
  logic               at_bot;
  logic               wrap_ev;
  logic               nat_upd;
  logic               upd;
  logic               tick;
  logic               wr;
  logic               acc;
  logic               soft_rst;
  logic               restart;
  logic               split;
  logic               dual;
  logic               wave_on;
  logic [5:0]         idx;
  logic [7:0]         flag_set;
  logic [7:0]         low_byte_counter_d;
  logic [7:0]         high_byte_counter_d;

  function automatic logic mapped(input logic [5:0] a);
    mapped = (a <= `TPW_IDX_CTRLFSET) || a == `TPW_IDX_INTFLAGS || a == `TPW_IDX_CNT ||
             a == `TPW_IDX_PER || a == `TPW_IDX_CMP0 || a == `TPW_IDX_CMP1 ||
             a == `TPW_IDX_CMP2 || a == `TPW_IDX_PERBUF || a == `TPW_IDX_CMP0BUF ||
             a == `TPW_IDX_CMP1BUF || a == `TPW_IDX_CMP2BUF;
  endfunction

  function automatic logic [5:0] cmp_idx(input int i, input logic buffered);
    logic [5:0] base;
    base = buffered ? `TPW_IDX_CMP0BUF : `TPW_IDX_CMP0;
    cmp_idx = base + 6'(2 * i);
  endfunction

  // Each byte lane lands on its own; split halves never disturb each other
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // APB decode: zero wait states, error on unmapped words
  assign idx     = paddr[7:2];
  assign acc     = psel && penable;
  assign wr      = acc && pwrite && mapped(idx);
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped(idx);
  assign prdata  = prdata_q;

  assign cmd = (wr && idx == `TPW_IDX_CTRLE_SET && pstrb[0]) ?
               tpw_pkg::tpw_cmd_t'(pwdata[`TPW_CTRLE_CMD +: 2]) :
               tpw_pkg::TPW_CMD_NONE;
  // A reset while running is dropped; software must stop the timer first
  assign soft_rst = (cmd == tpw_pkg::TPW_CMD_RESET) && !ctrl_q.enable;
  assign restart  = (cmd == tpw_pkg::TPW_CMD_RESTART);

  assign split = ctrl_q.dual_8bit_select;
  assign dual  = !split && (ctrl_q.waveform_select == tpw_pkg::TPW_WG_DS_TOP ||
                            ctrl_q.waveform_select == tpw_pkg::TPW_WG_DS_BOTH ||
                            ctrl_q.waveform_select == tpw_pkg::TPW_WG_DS_BOTTOM);
  assign wave_on = split || ctrl_q.waveform_select != tpw_pkg::TPW_WG_NORMAL;

  tpw_prescale u_prescale (
    .pclk            (pclk),
    .presetn         (presetn),
    .run             (ctrl_q.enable),
    .clear           (restart || soft_rst),
    .prescale_select (ctrl_q.prescale_select),
    .tick            (tick)
  );

  // Next count and direction for the 16-bit modes
  always_comb begin
    cnt_d  = cnt_q;
    dir_d  = dir_q;
    at_top = 1'b0;
    at_bot = 1'b0;
    if (dual) begin
      if (!dir_q) begin
        if (cnt_q >= per_q) begin
          dir_d  = 1'b1;
          cnt_d  = cnt_q - 16'h0001;
          at_top = 1'b1;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end else if (cnt_q == 16'h0000) begin
        dir_d  = 1'b0;
        cnt_d  = 16'h0001;
        at_bot = 1'b1;
      end else begin
        cnt_d = cnt_q - 16'h0001;
      end
    end else if (!dir_q) begin
      if (cnt_q >= per_q) begin
        cnt_d  = 16'h0000;
        at_bot = 1'b1;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end else if (cnt_q == 16'h0000) begin
      cnt_d  = per_q;
      at_bot = 1'b1;
    end else begin
      cnt_d = cnt_q - 16'h0001;
    end
  end

  // Split halves reload their own period byte at bottom
  assign low_byte_counter_d = (cnt_q[7:0] == 8'h00) ? per_q[7:0] : cnt_q[7:0] - 8'h01;
  assign high_byte_counter_d = (cnt_q[15:8] == 8'h00) ? per_q[15:8] : cnt_q[15:8] - 8'h01;

  assign wrap_ev = tick && (at_top || at_bot) && !(dual && at_top);

  always_comb begin
    case (ctrl_q.waveform_select)
      tpw_pkg::TPW_WG_DS_TOP:    nat_upd = at_top;
      tpw_pkg::TPW_WG_DS_BOTH:   nat_upd = at_top || at_bot;
      tpw_pkg::TPW_WG_DS_BOTTOM: nat_upd = at_bot;
      default:                   nat_upd = at_bot;
    endcase
  end

  // Buffers are dead in split mode, so no copy happens there
  assign upd = !split && ((tick && nat_upd && !update_lock_q) ||
                          cmd == tpw_pkg::TPW_CMD_UPDATE);

  // Waveform next state, per channel
  always_comb begin
    wo_d = wo_q;
    for (int i = 0; i < 3; i++) begin
      if (split) begin
        if (low_byte_counter_d == 8'h00) begin
          wo_d[i] = 1'b0;
        end else if (low_byte_counter_d == cmp_q[i][7:0]) begin
          wo_d[i] = 1'b1;
        end
        if (high_byte_counter_d == 8'h00) begin
          wo_d[i+3] = 1'b0;
        end else if (high_byte_counter_d == cmp_q[i][15:8]) begin
          wo_d[i+3] = 1'b1;
        end
      end else if (dual) begin
        if (cmp_q[i] == 16'h0000) begin
          wo_d[i] = 1'b0;
        end else if (cmp_q[i] >= per_q) begin
          wo_d[i] = 1'b1;
        end else if (cnt_d == 16'h0000) begin
          wo_d[i] = 1'b1;
        end else if (cnt_d == cmp_q[i]) begin
          wo_d[i] = dir_d;
        end
      end else if (ctrl_q.waveform_select == tpw_pkg::TPW_WG_SINGLE) begin
        if (cmp_q[i] == 16'h0000) begin
          wo_d[i] = 1'b0;
        end else if (cnt_d == 16'h0000) begin
          wo_d[i] = 1'b1;
        end else if (cnt_d == cmp_q[i]) begin
          wo_d[i] = 1'b0;
        end
      end
    end
  end

  // Flag sources; the high timer has no compare flags
  always_comb begin
    flag_set = 8'h00;
    if (tick) begin
      if (split) begin
        flag_set[`TPW_FLAG_OVF]  = cnt_q[7:0] == 8'h00;
        flag_set[`TPW_FLAG_HUNF] = cnt_q[15:8] == 8'h00;
        for (int i = 0; i < 3; i++) begin
          flag_set[`TPW_FLAG_CMP + i] = cnt_q[7:0] == cmp_q[i][7:0];
        end
      end else begin
        flag_set[`TPW_FLAG_OVF] = wrap_ev;
        for (int i = 0; i < 3; i++) begin
          flag_set[`TPW_FLAG_CMP + i] = cnt_q == cmp_q[i];
        end
      end
    end
  end

  assign ovf_lunf_pulse = flag_set[`TPW_FLAG_OVF];
  assign hunf_pulse     = flag_set[`TPW_FLAG_HUNF];
  assign cmp_pulse      = flag_set[`TPW_FLAG_CMP +: 3];

  // Control A to D
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
    end else if (soft_rst) begin
      ctrl_q <= '0;
    end else if (wr && pstrb[0]) begin
      case (idx)
        `TPW_IDX_CTRLA: begin
          ctrl_q.enable          <= pwdata[`TPW_CTRLA_EN];
          ctrl_q.prescale_select <= pwdata[`TPW_CTRLA_PSC_LO +: 3];
        end
        `TPW_IDX_CTRLB: begin
          ctrl_q.waveform_select       <= tpw_pkg::tpw_waveform_select_t'(pwdata[2:0]);
          ctrl_q.compare_output_enable <= pwdata[`TPW_CTRLB_CMPEN +: 3];
        end
        `TPW_IDX_CTRLC: ctrl_q.high_byte_output_enable <= pwdata[`TPW_CTRLC_HCMPEN +: 3];
        `TPW_IDX_CTRLD: ctrl_q.dual_8bit_select <= pwdata[`TPW_CTRLD_SPLIT];
        default: ;
      endcase
    end
  end

  // Control E: direction and update lock, set and clear locations
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q         <= 1'b0;
      update_lock_q <= 1'b0;
    end else if (soft_rst || restart) begin
      dir_q         <= 1'b0;
      update_lock_q <= soft_rst ? 1'b0 : update_lock_q;
    end else begin
      if (wr && pstrb[0] && idx == `TPW_IDX_CTRLE_SET) begin
        dir_q         <= dir_q | pwdata[`TPW_CTRLE_DIR];
        update_lock_q <= update_lock_q | pwdata[`TPW_CTRLE_LOCK];
      end else if (wr && pstrb[0] && idx == `TPW_IDX_CTRLECLR) begin
        dir_q         <= dir_q & ~pwdata[`TPW_CTRLE_DIR];
        update_lock_q <= update_lock_q & ~pwdata[`TPW_CTRLE_LOCK];
      end else if (tick && dual) begin
        dir_q <= dir_d;
      end
    end
  end

  // Counter: a software write beats counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
    end else if (soft_rst || restart) begin
      cnt_q <= 16'h0000;
    end else if (wr && idx == `TPW_IDX_CNT) begin
      cnt_q <= merge16(cnt_q, pwdata, pstrb);
    end else if (tick) begin
      cnt_q <= split ? {high_byte_counter_d, low_byte_counter_d} : cnt_d;
    end
  end

  // Period, compares, buffers and their valid flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_q    <= `TPW_PER_RST;
      perbuf_q <= `TPW_PER_RST;
      vld_q    <= 4'h0;
      for (int i = 0; i < 3; i++) begin
        cmp_q[i]    <= `TPW_CMP_RST;
        cmpbuf_q[i] <= `TPW_CMP_RST;
      end
    end else if (soft_rst) begin
      per_q    <= `TPW_PER_RST;
      perbuf_q <= `TPW_PER_RST;
      vld_q    <= 4'h0;
      for (int i = 0; i < 3; i++) begin
        cmp_q[i]    <= `TPW_CMP_RST;
        cmpbuf_q[i] <= `TPW_CMP_RST;
      end
    end else begin
      if (upd) begin
        if (vld_q[0]) begin
          per_q <= perbuf_q;
        end
        for (int i = 0; i < 3; i++) begin
          if (vld_q[i+1]) begin
            cmp_q[i] <= cmpbuf_q[i];
          end
        end
        vld_q <= 4'h0;
      end
      if (wr && pstrb[0] && idx == `TPW_IDX_CTRLFCLR) begin
        vld_q <= vld_q & ~pwdata[3:0];
      end
      if (wr && pstrb[0] && idx == `TPW_IDX_CTRLFSET && !split) begin
        vld_q <= vld_q | pwdata[3:0];
      end
      if (wr && idx == `TPW_IDX_PER) begin
        per_q <= merge16(per_q, pwdata, pstrb);
      end
      // A buffer write in the update cycle keeps its flag set
      if (wr && idx == `TPW_IDX_PERBUF) begin
        perbuf_q <= merge16(perbuf_q, pwdata, pstrb);
        vld_q[0] <= !split;
      end
      for (int i = 0; i < 3; i++) begin
        if (wr && idx == cmp_idx(i, 1'b0)) begin
          cmp_q[i] <= merge16(cmp_q[i], pwdata, pstrb);
        end
        if (wr && idx == cmp_idx(i, 1'b1)) begin
          cmpbuf_q[i] <= merge16(cmpbuf_q[i], pwdata, pstrb);
          vld_q[i+1]  <= !split;
        end
      end
    end
  end

  // Sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 8'h00;
    end else if (soft_rst) begin
      flags_q <= 8'h00;
    end else if (wr && pstrb[0] && idx == `TPW_IDX_INTFLAGS) begin
      flags_q <= (flags_q & ~pwdata[7:0]) | flag_set;
    end else begin
      flags_q <= flags_q | flag_set;
    end
  end

  // Outputs move on a tick, from registered state; a restart or soft reset clears them without one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wo_q <= 6'h00;
    end else if (soft_rst || restart) begin
      wo_q <= 6'h00;
    end else if (tick) begin
      wo_q <= wo_d;
    end
  end

  assign waveform_output_n = wo_q;

  // The pin direction itself stays with the port logic outside
  generate
    for (genvar g = 0; g < 3; g++) begin : g_ovr
      assign pin_override_n[g]   = ctrl_q.compare_output_enable[g] && wave_on;
      assign pin_override_n[g+3] = ctrl_q.high_byte_output_enable[g] && split;
    end
  endgenerate

  // Read data is captured in the setup phase and shown in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= 32'h00000000;
      case (paddr[7:2])
        `TPW_IDX_CTRLA:    prdata_q[3:0] <= {ctrl_q.prescale_select, ctrl_q.enable};
        `TPW_IDX_CTRLB:    prdata_q[6:0] <= {ctrl_q.compare_output_enable, 1'b0,
                                             ctrl_q.waveform_select};
        `TPW_IDX_CTRLC:    prdata_q[6:4] <= ctrl_q.high_byte_output_enable;
        `TPW_IDX_CTRLD:    prdata_q[0]   <= ctrl_q.dual_8bit_select;
        `TPW_IDX_CTRLECLR,
        `TPW_IDX_CTRLE_SET: prdata_q[1:0] <= {update_lock_q, dir_q};
        `TPW_IDX_CTRLFCLR,
        `TPW_IDX_CTRLFSET: prdata_q[3:0] <= vld_q;
        `TPW_IDX_INTFLAGS: prdata_q[7:0] <= flags_q;
        `TPW_IDX_CNT:      prdata_q[15:0] <= cnt_q;
        `TPW_IDX_PER:      prdata_q[15:0] <= per_q;
        `TPW_IDX_CMP0:     prdata_q[15:0] <= cmp_q[0];
        `TPW_IDX_CMP1:     prdata_q[15:0] <= cmp_q[1];
        `TPW_IDX_CMP2:     prdata_q[15:0] <= cmp_q[2];
        `TPW_IDX_PERBUF:   prdata_q[15:0] <= perbuf_q;
        `TPW_IDX_CMP0BUF:  prdata_q[15:0] <= cmpbuf_q[0];
        `TPW_IDX_CMP1BUF:  prdata_q[15:0] <= cmpbuf_q[1];
        `TPW_IDX_CMP2BUF:  prdata_q[15:0] <= cmpbuf_q[2];
        default:           prdata_q <= 32'h00000000;
      endcase
    end
  end

endmodule // tpw_timer_pwm

`default_nettype wire

// File: src/tpw_defines.svh
`ifndef TPW_DEFINES_SVH
`define TPW_DEFINES_SVH

// Register word indices; byte address is four times the index
`define TPW_IDX_CTRLA     6'h00
`define TPW_IDX_CTRLB     6'h01
`define TPW_IDX_CTRLC     6'h02
`define TPW_IDX_CTRLD     6'h03
`define TPW_IDX_CTRLECLR  6'h04
`define TPW_IDX_CTRLE_SET 6'h05
`define TPW_IDX_CTRLFCLR  6'h06
`define TPW_IDX_CTRLFSET  6'h07
`define TPW_IDX_INTFLAGS  6'h0B
`define TPW_IDX_CNT       6'h20
`define TPW_IDX_PER       6'h26
`define TPW_IDX_CMP0      6'h28
`define TPW_IDX_CMP1      6'h2A
`define TPW_IDX_CMP2      6'h2C
`define TPW_IDX_PERBUF    6'h36
`define TPW_IDX_CMP0BUF   6'h38
`define TPW_IDX_CMP1BUF   6'h3A
`define TPW_IDX_CMP2BUF   6'h3C

// Field positions
`define TPW_CTRLA_EN      0
`define TPW_CTRLA_PSC_LO  1
`define TPW_CTRLB_CMPEN   4
`define TPW_CTRLC_HCMPEN  4
`define TPW_CTRLD_SPLIT   0
`define TPW_CTRLE_DIR     0
`define TPW_CTRLE_LOCK    1
`define TPW_CTRLE_CMD     2
`define TPW_FLAG_OVF      0
`define TPW_FLAG_HUNF     1
`define TPW_FLAG_CMP      4

// Reset values
`define TPW_PER_RST       16'hFFFF
`define TPW_CMP_RST       16'h0000

// Prescaler divisor minus one, per prescale_select code
`define TPW_PSC_M0        10'h000
`define TPW_PSC_M1        10'h001
`define TPW_PSC_M2        10'h003
`define TPW_PSC_M3        10'h007
`define TPW_PSC_M4        10'h00F
`define TPW_PSC_M5        10'h03F
`define TPW_PSC_M6        10'h0FF
`define TPW_PSC_M7        10'h3FF

`endif

// File: src/tpw_pkg.sv
`default_nettype none
package tpw_pkg;

  typedef enum logic [2:0] {
    TPW_WG_NORMAL    = 3'b000,
    TPW_WG_FRQ       = 3'b001,
    TPW_WG_SINGLE    = 3'b011,
    TPW_WG_DS_TOP    = 3'b101,
    TPW_WG_DS_BOTH   = 3'b110,
    TPW_WG_DS_BOTTOM = 3'b111
  } tpw_waveform_select_t;

  typedef enum logic [1:0] {
    TPW_CMD_NONE    = 2'b00,
    TPW_CMD_UPDATE  = 2'b01,
    TPW_CMD_RESTART = 2'b10,
    TPW_CMD_RESET   = 2'b11
  } tpw_cmd_t;

  typedef struct packed {
    logic        enable;
    logic [2:0]  prescale_select;
    tpw_waveform_select_t waveform_select;
    logic [2:0]  compare_output_enable;
    logic [2:0]  high_byte_output_enable;
    logic        dual_8bit_select;
  } tpw_ctrl_t;

endpackage

`default_nettype wire

// File: src/tpw_prescale.sv
`timescale 1ns/100ps
`default_nettype none
`include "tpw_defines.svh"

module tpw_prescale (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic       clear,
  input  wire logic [2:0] prescale_select,
  output logic            tick
);

  logic [9:0] div_q;

  function automatic logic [9:0] psc_mask(input logic [2:0] s);
    case (s)
      3'h0:    psc_mask = `TPW_PSC_M0;
      3'h1:    psc_mask = `TPW_PSC_M1;
      3'h2:    psc_mask = `TPW_PSC_M2;
      3'h3:    psc_mask = `TPW_PSC_M3;
      3'h4:    psc_mask = `TPW_PSC_M4;
      3'h5:    psc_mask = `TPW_PSC_M5;
      3'h6:    psc_mask = `TPW_PSC_M6;
      default: psc_mask = `TPW_PSC_M7;
    endcase
  endfunction

  // Free divider, cleared while stopped so the first tick is a full division away
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 10'h000;
    end else if (!run || clear) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_q + 10'h001;
    end
  end

  assign tick = run && !clear &&
                ((div_q & psc_mask(prescale_select)) == psc_mask(prescale_select));

endmodule // tpw_prescale

`default_nettype wire

// File: testbench/tpw_timer_pwm_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module tpw_timer_pwm_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [5:0]  waveform_output_n,
  input wire logic [5:0]  pin_override_n,
  input wire logic        ovf_lunf_pulse,
  input wire logic        hunf_pulse
);
  logic       wr;
  logic       rst_cmd;
  logic       en_q;
  logic [6:0] ctrlb_q;
  logic [2:0] ctrlc_q;
  logic       split_q;
  // Shadow copies of the control bytes, kept from the bus alone
  assign wr      = psel && penable && pwrite && pstrb[0];
  assign rst_cmd = wr && paddr[7:2] == 6'h05 && pwdata[3:2] == 2'h3 && !en_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q    <= 1'b0;
      ctrlb_q <= 7'h00;
      ctrlc_q <= 3'h0;
      split_q <= 1'b0;
    end else if (rst_cmd) begin
      en_q    <= 1'b0;
      ctrlb_q <= 7'h00;
      ctrlc_q <= 3'h0;
      split_q <= 1'b0;
    end else if (wr) begin
      if (paddr[7:2] == 6'h00) en_q <= pwdata[0];
      if (paddr[7:2] == 6'h01) ctrlb_q <= pwdata[6:0];
      if (paddr[7:2] == 6'h02) ctrlc_q <= pwdata[6:4];
      if (paddr[7:2] == 6'h03) split_q <= pwdata[0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_at_once: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_restart_clears: assert property (wr && paddr[7:2] == 6'h05 && pwdata[3:2] == 2'h2
    |=> waveform_output_n == 6'h00) else $error("restart left outputs set");
  a_reset_clears: assert property (rst_cmd
    |=> waveform_output_n == 6'h00 && pin_override_n == 6'h00) else $error("reset kept state");
  a_override_low: assert property (pin_override_n[2:0] ==
    (ctrlb_q[6:4] & {3{split_q || ctrlb_q[2:0] != 3'h0}})) else $error("low override wrong");
  a_override_high: assert property (pin_override_n[5:3] ==
    (ctrlc_q & {3{split_q}})) else $error("high override wrong");
  a_hunf_split_only: assert property (hunf_pulse |-> split_q)
    else $error("high underflow outside split");
  a_hunf_spacing: assert property (hunf_pulse |=> !hunf_pulse [*3])
    else $error("high underflow too close");
  a_ovf_spacing: assert property (ovf_lunf_pulse |=> !ovf_lunf_pulse [*3])
    else $error("overflow too close");
endmodule // tpw_timer_pwm_monitor
`default_nettype wire

// File: testbench/tpw_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module tpw_pin_model (
  input  wire logic [5:0] override_n,
  input  wire logic [5:0] wave_n,
  input  wire logic [5:0] port_out,
  input  wire logic [5:0] pin_dir,
  output logic      [5:0] pin
);
  // An input pin is not driven; show the inverse latch so a stale level never passes
  always_comb begin
    for (int b = 0; b < 6; b++) begin
      if (!pin_dir[b]) pin[b] = ~port_out[b];
      else pin[b] = override_n[b] ? wave_n[b] : port_out[b];
    end
  end
endmodule // tpw_pin_model
`default_nettype wire

// File: testbench/tpw_timer_pwm_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module tpw_timer_pwm_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, ovf_lunf_pulse, hunf_pulse, err;
  logic [5:0]  waveform_output_n, pin_override_n, pin;
  logic [2:0]  cmp_pulse;
  int          failures = 0, compares = 0, cyc = 0, n_ovf, n_hunf, n_cmp0;
  int          hi [6];
  always #2 pclk = ~pclk;
  tpw_timer_pwm u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .waveform_output_n, .pin_override_n, .ovf_lunf_pulse,
    .hunf_pulse, .cmp_pulse);
  tpw_pin_model u_pin (.override_n(pin_override_n), .wave_n(waveform_output_n),
    .port_out(6'h2A), .pin_dir(6'h3F), .pin(pin));
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic apb(input logic w, input logic [5:0] i, input logic [15:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= {16'h0000, d};
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts whole periods, so the result does not depend on the window phase
  task automatic measure(input int n);
    hi     = '{default: 0};
    n_ovf  = 0;
    n_hunf = 0;
    n_cmp0 = 0;
    repeat (n) begin
      @(posedge pclk);
      #1;
      for (int b = 0; b < 6; b++) hi[b] += pin[b];
      n_ovf  += ovf_lunf_pulse;
      n_hunf += hunf_pulse;
      n_cmp0 += cmp_pulse[0];
    end
  endtask
  task automatic stop();
    apb(1, 6'h00, 16'h0000, 4'h1);
    apb(1, 6'h05, 16'h000C, 4'h1);
  endtask
  task automatic t_reset_vals();
    #1;
    `CHK("pin", 6'h2A, pin)
    apb(0, 6'h26, 16'h0000, 4'h0);
    `CHK("per", 32'hFFFF, rd)
    apb(0, 6'h3F, 16'h0000, 4'h0);
    `CHK("slverr", 1'b1, err)
  endtask
  task automatic t_single();
    apb(1, 6'h26, 16'h0007, 4'h3);
    apb(1, 6'h28, 16'h0003, 4'h3);
    apb(1, 6'h2C, 16'h0009, 4'h3);
    apb(1, 6'h01, 16'h0073, 4'h1);
    apb(1, 6'h00, 16'h0001, 4'h1);
    // Outputs start low until the first wrap, so skip that first period
    repeat (8) @(posedge pclk);
    measure(16);
    `CHK("ss wo0", 6, hi[0])
    `CHK("ss wo1", 0, hi[1])
    `CHK("ss wo2", 16, hi[2])
    `CHK("ss pin3", 16, hi[3])
    `CHK("ss ovf", 2, n_ovf)
    apb(1, 6'h00, 16'h0003, 4'h1);
    repeat (16) @(posedge pclk);
    measure(32);
    `CHK("ss div2", 12, hi[0])
  endtask
  task automatic t_commands();
    apb(1, 6'h05, 16'h0002, 4'h1);
    apb(1, 6'h38, 16'h0005, 4'h3);
    repeat (20) @(posedge pclk);
    apb(0, 6'h28, 16'h0000, 4'h0);
    `CHK("locked cmp0", 32'h3, rd)
    apb(0, 6'h07, 16'h0000, 4'h0);
    `CHK("vld set", 4'h2, rd[3:0])
    apb(1, 6'h05, 16'h0004, 4'h1);
    apb(0, 6'h28, 16'h0000, 4'h0);
    `CHK("upd cmp0", 32'h5, rd)
    apb(0, 6'h07, 16'h0000, 4'h0);
    `CHK("vld clr", 4'h0, rd[3:0])
    apb(1, 6'h05, 16'h0008, 4'h1);
    apb(0, 6'h20, 16'h0000, 4'h0);
    `CHK("restart cnt", 1'b1, rd[15:0] < 16'h0004)
    apb(1, 6'h05, 16'h000C, 4'h1);
    apb(0, 6'h26, 16'h0000, 4'h0);
    `CHK("reset ignored", 32'h7, rd)
    stop();
    apb(0, 6'h26, 16'h0000, 4'h0);
    `CHK("reset per", 32'hFFFF, rd)
    apb(0, 6'h01, 16'h0000, 4'h0);
    `CHK("reset ctrlb", 32'h0, rd)
  endtask
  task automatic t_dual();
    apb(1, 6'h26, 16'h0006, 4'h3);
    apb(1, 6'h28, 16'h0002, 4'h3);
    apb(1, 6'h2C, 16'h0006, 4'h3);
    apb(1, 6'h01, 16'h0075, 4'h1);
    apb(1, 6'h00, 16'h0001, 4'h1);
    repeat (14) @(posedge pclk);
    measure(24);
    `CHK("ds wo0", 8, hi[0])
    `CHK("ds wo1", 0, hi[1])
    `CHK("ds wo2", 24, hi[2])
    stop();
  endtask
  task automatic t_split();
    apb(1, 6'h03, 16'h0001, 4'h1);
    apb(1, 6'h26, 16'h0503, 4'h3);
    apb(1, 6'h28, 16'h0300, 4'h2);
    apb(1, 6'h28, 16'h0002, 4'h1);
    apb(1, 6'h01, 16'h0070, 4'h1);
    apb(1, 6'h02, 16'h0070, 4'h1);
    apb(1, 6'h00, 16'h0001, 4'h1);
    repeat (12) @(posedge pclk);
    measure(24);
    `CHK("lo wo0", 12, hi[0])
    `CHK("lo wo1", 0, hi[1])
    `CHK("hi wo0", 12, hi[3])
    `CHK("hi wo1", 0, hi[4])
    `CHK("hi wo2", 0, hi[5])
    `CHK("lunf", 6, n_ovf)
    `CHK("hunf", 4, n_hunf)
    `CHK("lcmp0", 6, n_cmp0)
    apb(0, 6'h0B, 16'h0000, 4'h0);
    `CHK("split flags", 32'h73, rd)
    apb(1, 6'h38, 16'h0001, 4'h1);
    apb(1, 6'h07, 16'h000F, 4'h1);
    apb(0, 6'h07, 16'h0000, 4'h0);
    `CHK("split vld", 32'h0, rd)
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_vals();
    t_single();
    t_commands();
    t_dual();
    t_split();
    give_verdict();
  end
endmodule // tpw_timer_pwm_tb
bind tpw_timer_pwm tpw_timer_pwm_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .pready, .waveform_output_n, .pin_override_n, .ovf_lunf_pulse,
  .hunf_pulse);
`default_nettype wire
